/* src/status_flag_params.svh */
// Constants of the device status flag registers: offsets, field positions,
// reset values and timing counts.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef STATUS_FLAG_PARAMS_SVH
`define STATUS_FLAG_PARAMS_SVH

// Register offsets on the 7-bit frame address
`define SUPPLY_FAULT_STATUS_ADDR 7'h40
`define THERMAL_PROTECTION_STATUS_ADDR 7'h41
`define DEVICE_INFORMATION_STATUS_ADDR 7'h42

// Supply register field positions
`define SUP_POWER_ON_BIT 15
`define SUP_INTERFACE_UV_BIT 8
`define SUP_PUMP_UV_BIT 4
`define SUP_SHORT_BIT 3
`define SUP_UNDERVOLTAGE_BIT 2
`define SUP_OVERVOLTAGE_BIT 1
`define SUP_PREWARNING_BIT 0
`define SUP_FLAG_WIDTH 13

// Thermal register field positions
`define THERM_SAFE_BIT 3
`define THERM_LEVEL_TWO_BIT 2
`define THERM_LEVEL_ONE_BIT 1
`define THERM_PREWARNING_BIT 0

// Reset values
`define SUP_POR_RESET 16'h8000
`define SUP_SOFT_RESET 16'h0000
`define THERM_RESET 16'h0000
`define DEV_RESET 16'h0000

// Thermal level-two safe-state threshold and long waiting time
`define LEVEL_TWO_SAFE_COUNT 5'h10
`define LEVEL_TWO_LONG_WAIT_S 64

// Clock and undervoltage duration under a short condition
`define CLK_MHZ 250
`define UV_SHORT_TIME_NS 2000000
`define UV_SHORT_CYCLES (`UV_SHORT_TIME_NS * `CLK_MHZ / 1000)

`endif

/* src/status_flag_pkg.sv */
// Types shared by the device status flag registers.
// Assumes status_flag_params.svh sits on the include path.
`include "status_flag_params.svh"

package status_flag_pkg;

	typedef enum logic [5:0] {
		MODE_INIT = 6'h01,
		MODE_NORMAL = 6'h02,
		MODE_STOP = 6'h04,
		MODE_SLEEP = 6'h08,
		MODE_RESTART = 6'h10,
		MODE_FAILSAFE = 6'h20
	} mode_type;

	typedef struct packed {
		logic valid;
		logic clear;
		logic [6:0] addr;
	} frame_type;

	typedef struct packed {
		logic prewarning;
		logic level_one;
		logic level_two;
	} thermal_level_type;

	typedef struct packed {
		logic crc_fail;
		logic crc_static_seq;
		logic spi_invalid;
		logic failure;
		logic wd_expired;
		logic wd_service_ok;
	} device_event_type;

	typedef struct packed {
		logic [12:0] supply_flags;
		logic power_on_flag;
		logic [3:0] thermal_flags;
		logic crc_fail_flag;
		logic [1:0] prior_state_field;
		logic [1:0] watchdog_failure_counter;
		logic spi_fail_flag;
		logic failure_flag;
		logic level_two_seen;
		logic [4:0] level_two_count;
		logic long_wait;
		logic failsafe_req;
		logic module_off;
		logic [15:0] rd_data;
		logic rd_valid;
	} state_type;

endpackage

/* src/level_sync.sv */
// Two-flop synchroniser bank for comparator levels from outside the clock.
// Assumes the levels are quasi-static compared with the clock period.
`timescale 1ns/1ps
`default_nettype none

module level_sync #(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_output_low,
	// Levels
	input wire logic [WIDTH-1:0] level_async,
	output logic [WIDTH-1:0] level_sync_out
);

	logic [WIDTH-1:0] meta_r;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			always_ff @(posedge clk)
			begin
				if (!reset_output_low)
				begin
					meta_r[i] <= 1'b0;
					level_sync_out[i] <= 1'b0;
				end
				else
				begin
					meta_r[i] <= level_async[i];
					level_sync_out[i] <= meta_r[i];
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

/* src/uv_duration_timer.sv */
// Measures how long the regulator undervoltage level has stood.
// Assumes a synchronised level on the block clock.
`timescale 1ns/1ps
`default_nettype none
`include "status_flag_params.svh"

module uv_duration_timer #(
	parameter int unsigned LIMIT_CYCLES = `UV_SHORT_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_output_low,
	// Level and result
	input wire logic uv_level,
	output logic uv_long_r
);

	logic [19:0] count_r;
	logic [19:0] limit;

	assign limit = LIMIT_CYCLES[19:0];

	// Strictly longer than the limit, so the count saturates one past it
	always_ff @(posedge clk)
	begin
		if (!reset_output_low)
		begin
			count_r <= 20'h0;
			uv_long_r <= 1'b0;
		end
		else if (!uv_level)
		begin
			count_r <= 20'h0;
			uv_long_r <= 1'b0;
		end
		else
		begin
			if (count_r <= limit)
			begin
				count_r <= count_r + 20'h1;
			end
			uv_long_r <= (count_r > limit);
		end
	end

endmodule

`default_nettype wire

/* src/status_flag_registers.sv */
// Sticky supply, thermal and device information status registers.
// Assumes mode, reset-pin and config inputs come from logic on clk,
// comparator levels arrive asynchronously, frames come one per request.
// Summary of operation
// - Supply bits 4..0 latch pump UV, short, regulator UV, OV, prewarning.
// - Power-on reset leaves only the top power flag; soft reset clears it.
// - Stop Mode masks interface UV unless load peak or prewarning flag.
// - Sleep with regulator off never sets short, overvoltage or undervoltage.
// - Regulator UV gated by mode; long UV during a short updates unless Sleep has the regulator off.
// - Thermal bits 15..4 read zero; four flags survive restart.
// - Safe-state flag after more than 16 level-two events outside Normal Mode; long wait then.
// - Level two requests fail-safe; level one disables the affected module.
// - Thermal flags stay set after the condition disappears.
// - Information bits 15..10 zero; bit 9 shows checksum protection enable.
// - Bit 8 latches checksum failure, never for the static enable sequence.
// - Bits 7..6 record the state before restart: failure 01, sleep 10.
// - Bit 4 shows development mode live; bit 5 reads zero.
// - Bits 3..2 count watchdog failures, saturating at three.
// - Bit 1 latches an invalid command.
// - Bit 0 latches any failure.
// - Frame bit 7 low reads; high clears the register except the watchdog counter.
// - Only the watchdog counter is cleared by the device itself.
`timescale 1ns/1ps
`default_nettype none
`include "status_flag_params.svh"

module status_flag_registers
	import status_flag_pkg::*;
#(
	parameter int unsigned UV_LIMIT_CYCLES = `UV_SHORT_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_output_low,
	// Device control from the mode logic
	input wire mode_type mode,
	input wire logic soft_reset_req,
	input wire logic restart_req,
	input wire logic [1:0] restart_cause,
	input wire logic reset_out_released,
	input wire logic regulator_off,
	input wire logic load_peak_above,
	input wire logic crc_enabled,
	input wire logic software_development_indicator,
	// Comparator levels, asynchronous
	input wire logic [12:0] supply_level,
	input wire thermal_level_type thermal_level,
	// Device events
	input wire device_event_type dev_event,
	// Status frame
	input wire frame_type frame,
	output logic [15:0] rd_data_r,
	output logic rd_valid_r,
	// Protection actions
	output logic failsafe_req_r,
	output logic long_wait_r,
	output logic module_off_r
);

	state_type st;
	state_type nxt;
	logic [15:0] sync_out;
	logic [12:0] sup_lvl;
	thermal_level_type therm_lvl;
	logic uv_long_r;
	logic [12:0] sup_set;
	logic [3:0] therm_set;
	logic level_two_evt;
	logic safe_evt;
	logic uv_update_ok;
	logic clr_sup;
	logic clr_therm;
	logic clr_dev;

	// Address decode shared by the clear and read paths
	function automatic logic frame_hit(frame_type f, logic [6:0] a);
		frame_hit = f.valid && (f.addr == a);
	endfunction

	// Set dominates clear
	function automatic logic [12:0] sticky(logic [12:0] old_v,
		logic [12:0] set_v, logic clr);
		sticky = (clr ? 13'h0 : old_v) | set_v;
	endfunction

	level_sync #(
		.WIDTH(16)
	) u_sync (
		.clk(clk),
		.reset_output_low(reset_output_low),
		.level_async({supply_level, thermal_level}),
		.level_sync_out(sync_out)
	);

	assign sup_lvl = sync_out[15:3];
	assign therm_lvl = sync_out[2:0];

	uv_duration_timer #(
		.LIMIT_CYCLES(UV_LIMIT_CYCLES)
	) u_uv_timer (
		.clk(clk),
		.reset_output_low(reset_output_low),
		.uv_level(sup_lvl[`SUP_UNDERVOLTAGE_BIT]),
		.uv_long_r(uv_long_r)
	);

	always_comb
	begin
		nxt = st;
		nxt.rd_valid = 1'b0;
		nxt.failsafe_req = 1'b0;
		clr_sup = frame_hit(frame, `SUPPLY_FAULT_STATUS_ADDR)
			&& frame.clear;
		clr_therm = frame_hit(frame, `THERMAL_PROTECTION_STATUS_ADDR)
			&& frame.clear;
		clr_dev = frame_hit(frame, `DEVICE_INFORMATION_STATUS_ADDR)
			&& frame.clear;

		// Supply comparators; interface UV, short, regulator UV and OV gated by mode
		sup_set = sup_lvl;
		if (mode == MODE_STOP && !load_peak_above
			&& !st.supply_flags[`SUP_PREWARNING_BIT])
		begin
			sup_set[`SUP_INTERFACE_UV_BIT] = 1'b0;
		end
		uv_update_ok = (mode == MODE_NORMAL) || (mode == MODE_STOP)
			|| (mode == MODE_INIT && reset_out_released)
			|| (uv_long_r && sup_lvl[`SUP_SHORT_BIT]);
		if (!uv_update_ok)
		begin
			sup_set[`SUP_UNDERVOLTAGE_BIT] = 1'b0;
		end
		// Regulator off in sleep gives meaningless comparator outputs
		if (mode == MODE_SLEEP && regulator_off)
		begin
			sup_set[`SUP_SHORT_BIT] = 1'b0;
			sup_set[`SUP_UNDERVOLTAGE_BIT] = 1'b0;
			sup_set[`SUP_OVERVOLTAGE_BIT] = 1'b0;
		end
		nxt.supply_flags = sticky(st.supply_flags, sup_set, clr_sup);
		nxt.power_on_flag = st.power_on_flag && !clr_sup;

		// Thermal events; level two counts each new rising edge outside Normal Mode, saturating at 31
		level_two_evt = therm_lvl.level_two && !st.level_two_seen;
		nxt.level_two_seen = therm_lvl.level_two;
		safe_evt = level_two_evt
			&& (st.level_two_count >= `LEVEL_TWO_SAFE_COUNT);
		if (mode == MODE_NORMAL)
		begin
			nxt.level_two_count = 5'h0;
			nxt.long_wait = 1'b0;
		end
		else if (level_two_evt && st.level_two_count != 5'h1f)
		begin
			nxt.level_two_count = st.level_two_count + 5'h1;
		end
		if (safe_evt)
		begin
			nxt.long_wait = 1'b1;
		end
		therm_set = 4'h0;
		therm_set[`THERM_SAFE_BIT] = safe_evt;
		therm_set[`THERM_LEVEL_TWO_BIT] = level_two_evt;
		therm_set[`THERM_LEVEL_ONE_BIT] = therm_lvl.level_one;
		therm_set[`THERM_PREWARNING_BIT] = therm_lvl.prewarning;
		nxt.thermal_flags = (clr_therm ? 4'h0 : st.thermal_flags)
			| therm_set;
		nxt.failsafe_req = level_two_evt;
		nxt.module_off = therm_lvl.level_one;

		// Device information flags
		nxt.crc_fail_flag = (st.crc_fail_flag && !clr_dev)
			|| (dev_event.crc_fail && !dev_event.crc_static_seq);
		nxt.spi_fail_flag = (st.spi_fail_flag && !clr_dev)
			|| dev_event.spi_invalid;
		nxt.failure_flag = (st.failure_flag && !clr_dev)
			|| dev_event.failure;
		if (restart_req)
		begin
			nxt.prior_state_field = restart_cause;
		end
		else if (clr_dev)
		begin
			nxt.prior_state_field = 2'b00;
		end
		// Host clears leave the counter alone; the device resets it
		if (dev_event.wd_expired)
		begin
			if (st.watchdog_failure_counter != 2'b11)
			begin
				nxt.watchdog_failure_counter =
					st.watchdog_failure_counter + 2'b01;
			end
		end
		else if (dev_event.wd_service_ok)
		begin
			nxt.watchdog_failure_counter = 2'b00;
		end

		// Answer carries the content seen before any clear
		if (frame_hit(frame, `SUPPLY_FAULT_STATUS_ADDR))
		begin
			nxt.rd_valid = 1'b1;
			nxt.rd_data = {st.power_on_flag, 2'b00, st.supply_flags};
		end
		else if (frame_hit(frame, `THERMAL_PROTECTION_STATUS_ADDR))
		begin
			nxt.rd_valid = 1'b1;
			nxt.rd_data = {12'h000, st.thermal_flags};
		end
		else if (frame_hit(frame, `DEVICE_INFORMATION_STATUS_ADDR))
		begin
			nxt.rd_valid = 1'b1;
			nxt.rd_data = {6'h00, crc_enabled, st.crc_fail_flag,
				st.prior_state_field, 1'b0,
				software_development_indicator,
				st.watchdog_failure_counter, st.spi_fail_flag,
				st.failure_flag};
		end

		// Soft reset clears every register, the power flag included
		if (soft_reset_req)
		begin
			nxt.supply_flags = 13'(`SUP_SOFT_RESET);
			nxt.power_on_flag = 1'b0;
			nxt.thermal_flags = 4'h0;
			nxt.crc_fail_flag = 1'b0;
			nxt.prior_state_field = 2'b00;
			nxt.watchdog_failure_counter = 2'b00;
			nxt.spi_fail_flag = 1'b0;
			nxt.failure_flag = 1'b0;
			nxt.level_two_count = 5'h0;
			nxt.long_wait = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_output_low)
		begin
			st <= '0;
			st.power_on_flag <= 1'b1;
		end
		else
		begin
			st <= nxt;
		end
	end

	assign rd_data_r = st.rd_data;
	assign rd_valid_r = st.rd_valid;
	assign failsafe_req_r = st.failsafe_req;
	assign long_wait_r = st.long_wait;
	assign module_off_r = st.module_off;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_output_low);

	sequence read_frame(logic [6:0] a);
		frame.valid && frame.addr == a;
	endsequence

	sequence answer_next;
		##1 rd_valid_r;
	endsequence

	a_set_wins_clear: assert property (
		(sup_set[`SUP_PUMP_UV_BIT] && clr_sup && !soft_reset_req)
		|=> st.supply_flags[`SUP_PUMP_UV_BIT])
		else $error("supply flag lost when set met clear");

	a_stop_uv_mask: assert property (
		(mode == MODE_STOP && !load_peak_above
		&& !st.supply_flags[`SUP_PREWARNING_BIT]
		&& !st.supply_flags[`SUP_INTERFACE_UV_BIT])
		|=> !st.supply_flags[`SUP_INTERFACE_UV_BIT])
		else $error("interface undervoltage set in stop mode");

	a_sleep_off_mask: assert property (
		(mode == MODE_SLEEP && regulator_off && clr_sup)
		|=> st.supply_flags[3:1] == 3'b000)
		else $error("regulator flag set with regulator off");

	a_restart_uv_hold: assert property (
		(mode == MODE_RESTART && !uv_long_r
		&& !st.supply_flags[`SUP_UNDERVOLTAGE_BIT])
		|=> !st.supply_flags[`SUP_UNDERVOLTAGE_BIT])
		else $error("regulator undervoltage updated in restart");

	a_safe_after_count: assert property (
		(level_two_evt && st.level_two_count == `LEVEL_TWO_SAFE_COUNT)
		|=> st.thermal_flags[`THERM_SAFE_BIT] && long_wait_r)
		else $error("safe state missing after seventeenth event");

	a_safe_not_early: assert property (
		(st.level_two_count < `LEVEL_TWO_SAFE_COUNT
		&& !st.thermal_flags[`THERM_SAFE_BIT])
		|=> !st.thermal_flags[`THERM_SAFE_BIT])
		else $error("safe state set too early");

	a_failsafe_pulse: assert property (
		level_two_evt |=> failsafe_req_r ##1 !failsafe_req_r)
		else $error("fail-safe request not a single pulse");

	a_thermal_hold: assert property (
		(st.thermal_flags != 4'h0 && !clr_therm && !soft_reset_req)
		|=> (st.thermal_flags & $past(st.thermal_flags))
		== $past(st.thermal_flags))
		else $error("thermal flag dropped without clear");

	a_crc_static: assert property (
		(dev_event.crc_static_seq && !st.crc_fail_flag)
		|=> !st.crc_fail_flag)
		else $error("checksum failure set by static sequence");

	a_wd_saturate: assert property (
		(st.watchdog_failure_counter == 2'b11 && dev_event.wd_expired)
		|=> st.watchdog_failure_counter == 2'b11)
		else $error("watchdog counter wrapped");

	a_dev_read_zero: assert property (
		read_frame(`DEVICE_INFORMATION_STATUS_ADDR) |-> answer_next
		##0 (rd_data_r[15:10] == 6'h00 && rd_data_r[5] == 1'b0))
		else $error("information reserved bits not zero");

	a_soft_reset: assert property (
		soft_reset_req |=> st.power_on_flag == 1'b0
		&& st.thermal_flags == 4'h0)
		else $error("soft reset left flags set");

	a_spi_fail_set: assert property (
		(dev_event.spi_invalid && !soft_reset_req) |=> st.spi_fail_flag)
		else $error("invalid command flag not set");

	a_prior_state_load: assert property (
		(restart_req && !soft_reset_req)
		|=> st.prior_state_field == $past(restart_cause))
		else $error("prior state not recorded at restart");

endmodule

`default_nettype wire

/* dv/status_host_model.sv */
// Host side of the status frame: issues one read or clear frame per call.
// Assumes the bench calls access() one cycle at a time after reset release.
`timescale 1ns/1ps
`default_nettype none

module status_host_model
	import status_flag_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_output_low,
	// Frame and answer
	output var frame_type frame,
	input wire logic rd_valid_r,
	input wire logic [15:0] rd_data_r
);
	initial frame = '0;

	// Valid stands one cycle; idle lines show the inverse so no stale match
	task automatic access(input logic [6:0] a, input logic c,
		output logic [15:0] d, output logic ok);
		int n;
		begin
			ok = 1'b0;
			d = '0;
			@(posedge clk);
			#1;
			frame = '{valid: 1'b1, clear: c, addr: a};
			@(posedge clk);
			#1;
			frame = '{valid: 1'b0, clear: ~c, addr: ~a};
			for (n = 0; n < 4 && !ok; n++)
			begin
				if (rd_valid_r === 1'b1)
				begin
					ok = 1'b1;
					d = rd_data_r;
				end
				else
				begin
					@(posedge clk);
					#1;
				end
			end
		end
	endtask
endmodule

`default_nettype wire

/* dv/status_flag_registers_bench.sv */
// Self-checking bench for the status flag registers.
// Assumes the host model drives frames; all other inputs come from here.
`timescale 1ns/1ps
`default_nettype none
`include "status_flag_params.svh"

module status_flag_registers_bench
	import status_flag_pkg::*;
;
	typedef struct packed {
		logic [12:0] sup;
		logic [2:0] th;
		logic [5:0] ev;
		logic [6:0] addr;
		logic [15:0] exp;
	} row_type;

	logic clk = 1'b0;
	logic reset_output_low = 1'b0;
	mode_type mode = MODE_NORMAL;
	logic soft_reset_req = 1'b0;
	logic restart_req = 1'b0;
	logic [1:0] restart_cause = 2'b00;
	logic reset_out_released = 1'b0;
	logic regulator_off = 1'b0;
	logic load_peak_above = 1'b0;
	logic crc_enabled = 1'b1;
	logic devel_mode = 1'b0;
	logic [12:0] supply_level = '0;
	thermal_level_type thermal_level = '0;
	device_event_type dev_event = '0;
	frame_type frame;
	logic [15:0] rd_data_r;
	logic rd_valid_r, failsafe_req_r, long_wait_r, module_off_r;
	int num_errors = 0;
	int checked = 0;
	int fs_pulses = 0;
	int i;
	row_type rows [12] = '{
		'{13'h010, 3'h0, 6'h00, `SUPPLY_FAULT_STATUS_ADDR, 16'h0010},
		'{13'h008, 3'h0, 6'h00, `SUPPLY_FAULT_STATUS_ADDR, 16'h0008},
		'{13'h004, 3'h0, 6'h00, `SUPPLY_FAULT_STATUS_ADDR, 16'h0004},
		'{13'h002, 3'h0, 6'h00, `SUPPLY_FAULT_STATUS_ADDR, 16'h0002},
		'{13'h001, 3'h0, 6'h00, `SUPPLY_FAULT_STATUS_ADDR, 16'h0001},
		'{13'h000, 3'h4, 6'h00, `THERMAL_PROTECTION_STATUS_ADDR, 16'h0001},
		'{13'h000, 3'h2, 6'h00, `THERMAL_PROTECTION_STATUS_ADDR, 16'h0002},
		'{13'h000, 3'h1, 6'h00, `THERMAL_PROTECTION_STATUS_ADDR, 16'h0004},
		'{13'h000, 3'h0, 6'h20, `DEVICE_INFORMATION_STATUS_ADDR, 16'h0300},
		'{13'h000, 3'h0, 6'h08, `DEVICE_INFORMATION_STATUS_ADDR, 16'h0202},
		'{13'h000, 3'h0, 6'h04, `DEVICE_INFORMATION_STATUS_ADDR, 16'h0201},
		'{13'h000, 3'h0, 6'h30, `DEVICE_INFORMATION_STATUS_ADDR, 16'h0200}
	};

	always #2 clk = ~clk;

	always @(posedge clk)
		if (failsafe_req_r === 1'b1)
			fs_pulses++;

	// Short limit keeps the long-undervoltage case to a few dozen cycles
	status_flag_registers #(.UV_LIMIT_CYCLES(20)) i_dut (
		.clk(clk), .reset_output_low(reset_output_low), .mode(mode),
		.soft_reset_req(soft_reset_req), .restart_req(restart_req),
		.restart_cause(restart_cause),
		.reset_out_released(reset_out_released),
		.regulator_off(regulator_off), .load_peak_above(load_peak_above),
		.crc_enabled(crc_enabled),
		.software_development_indicator(devel_mode),
		.supply_level(supply_level), .thermal_level(thermal_level),
		.dev_event(dev_event), .frame(frame), .rd_data_r(rd_data_r),
		.rd_valid_r(rd_valid_r), .failsafe_req_r(failsafe_req_r),
		.long_wait_r(long_wait_r), .module_off_r(module_off_r)
	);

	status_host_model i_host (
		.clk(clk), .reset_output_low(reset_output_low), .frame(frame),
		.rd_valid_r(rd_valid_r), .rd_data_r(rd_data_r)
	);

	task automatic complete_run;
		if (num_errors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rd(input logic [6:0] a, input logic c,
		input logic [15:0] exp);
		logic [15:0] d;
		logic ok;
		i_host.access(a, c, d, ok);
		chk({15'h0, ok}, 16'h0001);
		chk(d, exp);
	endtask

	// Level held, dropped, then read-clear and a read back
	task automatic hit(input logic [12:0] s, input logic [2:0] t,
		input logic [5:0] e, input logic [6:0] a, input logic [15:0] x,
		input int hold);
		supply_level = s;
		thermal_level = t;
		dev_event = e;
		tick(1);
		dev_event = '0;
		tick(hold);
		supply_level = '0;
		thermal_level = '0;
		tick(5);
		rd(a, 1'b1, x);
		rd(a, 1'b0, (a == `DEVICE_INFORMATION_STATUS_ADDR) ? 16'h0200 : 16'h0);
	endtask

	initial
	begin
		repeat (100000) @(posedge clk);
		num_errors++;
		$display("[FAIL] %0t run did not finish", $time);
		complete_run;
	end

	initial
	begin
		logic [15:0] d;
		logic ok;
		tick(3);
		reset_output_low = 1'b1;
		rd(`SUPPLY_FAULT_STATUS_ADDR, 1'b0, 16'h8000);
		rd(`THERMAL_PROTECTION_STATUS_ADDR, 1'b0, 16'h0000);
		rd(`DEVICE_INFORMATION_STATUS_ADDR, 1'b0, 16'h0200);
		soft_reset_req = 1'b1;
		tick(1);
		soft_reset_req = 1'b0;
		rd(`SUPPLY_FAULT_STATUS_ADDR, 1'b0, 16'h0000);
		i_host.access(7'h43, 1'b0, d, ok);
		chk({15'h0, ok}, 16'h0000);
		for (i = 0; i < 12; i++)
			hit(rows[i].sup, rows[i].th, rows[i].ev, rows[i].addr,
				rows[i].exp, 2);
		mode = MODE_STOP;
		hit(13'h100, 3'h0, 6'h0, `SUPPLY_FAULT_STATUS_ADDR, 16'h0, 2);
		load_peak_above = 1'b1;
		hit(13'h100, 3'h0, 6'h0, `SUPPLY_FAULT_STATUS_ADDR, 16'h0100, 2);
		mode = MODE_SLEEP;
		regulator_off = 1'b1;
		hit(13'h00e, 3'h0, 6'h0, `SUPPLY_FAULT_STATUS_ADDR, 16'h0, 2);
		regulator_off = 1'b0;
		hit(13'h00e, 3'h0, 6'h0, `SUPPLY_FAULT_STATUS_ADDR, 16'h000a, 2);
		mode = MODE_RESTART;
		hit(13'h004, 3'h0, 6'h0, `SUPPLY_FAULT_STATUS_ADDR, 16'h0, 2);
		hit(13'h00c, 3'h0, 6'h0, `SUPPLY_FAULT_STATUS_ADDR, 16'h000c, 30);
		mode = MODE_INIT;
		hit(13'h004, 3'h0, 6'h0, `SUPPLY_FAULT_STATUS_ADDR, 16'h0, 2);
		reset_out_released = 1'b1;
		hit(13'h004, 3'h0, 6'h0, `SUPPLY_FAULT_STATUS_ADDR, 16'h0004, 2);
		mode = MODE_FAILSAFE;
		thermal_level = 3'h2;
		tick(5);
		chk({15'h0, module_off_r}, 16'h0001);
		thermal_level = '0;
		tick(5);
		chk({15'h0, module_off_r}, 16'h0000);
		rd(`THERMAL_PROTECTION_STATUS_ADDR, 1'b1, 16'h0002);
		for (i = 0; i < 17; i++)
		begin
			if (i == 16)
				rd(`THERMAL_PROTECTION_STATUS_ADDR, 1'b0, 16'h0004);
			thermal_level = 3'h1;
			tick(3);
			thermal_level = '0;
			tick(3);
		end
		tick(2);
		rd(`THERMAL_PROTECTION_STATUS_ADDR, 1'b0, 16'h000c);
		chk({15'h0, long_wait_r}, 16'h0001);
		chk(16'(fs_pulses), 16'h0012);
		restart_cause = 2'b01;
		restart_req = 1'b1;
		tick(1);
		restart_req = 1'b0;
		rd(`DEVICE_INFORMATION_STATUS_ADDR, 1'b1, 16'h0240);
		restart_cause = 2'b10;
		restart_req = 1'b1;
		tick(1);
		restart_req = 1'b0;
		rd(`DEVICE_INFORMATION_STATUS_ADDR, 1'b1, 16'h0280);
		devel_mode = 1'b1;
		crc_enabled = 1'b0;
		tick(1);
		rd(`DEVICE_INFORMATION_STATUS_ADDR, 1'b1, 16'h0010);
		devel_mode = 1'b0;
		crc_enabled = 1'b1;
		for (i = 1; i < 5; i++)
		begin
			dev_event = 6'h02;
			tick(1);
			dev_event = '0;
			rd(`DEVICE_INFORMATION_STATUS_ADDR, 1'b1,
				16'h0200 | 16'((i > 3 ? 3 : i) << 2));
		end
		dev_event = 6'h01;
		tick(1);
		dev_event = '0;
		rd(`DEVICE_INFORMATION_STATUS_ADDR, 1'b0, 16'h0200);
		fork
			rd(`DEVICE_INFORMATION_STATUS_ADDR, 1'b1, 16'h0200);
			begin
				@(posedge clk);
				#1;
				dev_event = 6'h08;
				tick(1);
				dev_event = '0;
			end
		join
		rd(`DEVICE_INFORMATION_STATUS_ADDR, 1'b0, 16'h0202);
		// Level still present while the clear lands: the flag must survive
		supply_level = 13'h010;
		tick(3);
		rd(`SUPPLY_FAULT_STATUS_ADDR, 1'b1, 16'h0010);
		rd(`SUPPLY_FAULT_STATUS_ADDR, 1'b0, 16'h0010);
		supply_level = '0;
		tick(3);
		rd(`SUPPLY_FAULT_STATUS_ADDR, 1'b1, 16'h0010);
		rd(`SUPPLY_FAULT_STATUS_ADDR, 1'b0, 16'h0000);
		// Power-on reset in mid-run brings the power flag back
		reset_output_low = 1'b0;
		tick(3);
		reset_output_low = 1'b1;
		rd(`SUPPLY_FAULT_STATUS_ADDR, 1'b0, 16'h8000);
		rd(`THERMAL_PROTECTION_STATUS_ADDR, 1'b0, 16'h0000);
		complete_run;
	end
endmodule

`default_nettype wire
